// [hvmrc_pkg.sv]
package hvmrc_pkg;

  // Register word addresses
  localparam logic [3:0] HVMRC_ADDR_CTRL = 4'h0;
  localparam logic [3:0] HVMRC_ADDR_GPIO = 4'h1;
  localparam logic [3:0] HVMRC_ADDR_PULL = 4'h2;
  localparam logic [3:0] HVMRC_ADDR_WKSRC = 4'h3;
  localparam logic [3:0] HVMRC_ADDR_STAT = 4'h4;
  localparam logic [3:0] HVMRC_ADDR_IRQ_STAT = 4'h5;
  localparam logic [3:0] HVMRC_ADDR_IRQ_MASK = 4'h6;
  localparam logic [3:0] HVMRC_ADDR_WKFLAG = 4'h7;
  localparam logic [3:0] HVMRC_ADDR_WKLVL = 4'h8;
  localparam logic [3:0] HVMRC_ADDR_CMD = 4'h9;

  // Field positions
  localparam int HVMRC_CTRL_MEAS_BIT = 0;
  localparam int HVMRC_CMD_SLEEP_BIT = 0;
  localparam int HVMRC_WKSRC_SENSE_BIT = 0;
  localparam int HVMRC_WKSRC_GPIO_BIT = 1;
  localparam int HVMRC_WKSRC_OTHER_BIT = 2;
  localparam int HVMRC_IRQ_CMD_ERR_BIT = 0;
  localparam int HVMRC_IRQ_WAKE_BIT = 1;
  localparam int HVMRC_IRQ_RESTART_BIT = 2;

  // Reset values, widths and GPIO modes
  localparam int HVMRC_IRQ_W = 3;
  localparam logic [2:0] HVMRC_GPIO_OFF = 3'h0;
  localparam logic [2:0] HVMRC_GPIO_FAILOUT = 3'h1;
  localparam logic [2:0] HVMRC_GPIO_WAKE = 3'h2;
  localparam logic [3:0] HVMRC_PULL_RST = 4'h0;
  localparam logic [2:0] HVMRC_WKSRC_RST = 3'h1;
  localparam logic [2:0] HVMRC_IRQ_MASK_RST = 3'h0;

  typedef enum logic [2:0] {
    HVMRC_MODE_INIT,
    HVMRC_MODE_NORMAL,
    HVMRC_MODE_STOP,
    HVMRC_MODE_SLEEP,
    HVMRC_MODE_RESTART,
    HVMRC_MODE_FAILSAFE
  } hvmrc_mode_t;

  typedef struct packed {
    logic [3:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } hvmrc_av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } hvmrc_av_rsp_t;

  typedef struct packed {
    logic sense_pu;
    logic sense_pd;
    logic shared_pu;
    logic shared_pd;
  } hvmrc_pull_t;

endpackage : hvmrc_pkg

// [hvmrc_pin_gate.sv]
`timescale 1ns/1ps
module hvmrc_pin_gate
  import hvmrc_pkg::*;
(
  input wire logic meas_i,
  input wire logic [3:0] pull_cfg_i,
  input wire logic [2:0] gpio_cfg_i,
  input wire logic fail_output_req_i,
  input wire logic fail_output_test_i,
  input wire logic hv_wake_sense_pin_i,
  input wire logic failout_shared_pin_i,
  output hvmrc_pkg::hvmrc_pull_t pull_o,
  output logic sense_in_o,
  output logic shared_in_o,
  output logic fail_output_o,
  output logic shared_oe_n_o
);
  logic fail_output_test;

  always_comb begin
    pull_o = meas_i ? '0 : hvmrc_pull_t'(pull_cfg_i);
    sense_in_o = hv_wake_sense_pin_i & ~meas_i;
    shared_in_o = failout_shared_pin_i & ~meas_i;
    fail_output_test = (gpio_cfg_i == HVMRC_GPIO_FAILOUT) & (fail_output_req_i | fail_output_test_i);
    fail_output_o = fail_output_test & ~meas_i;
    shared_oe_n_o = ~(fail_output_test & ~meas_i);
  end
endmodule : hvmrc_pin_gate

// [hvmrc_wake_track.sv]
`timescale 1ns/1ps
module hvmrc_wake_track
  import hvmrc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic sense_in_i,
  input wire logic shared_in_i,
  input wire logic meas_i,
  input wire logic shared_wake_en_i,
  input wire logic clr_flags_i,
  output logic [1:0] flags_o,
  output logic [1:0] level_o,
  output logic wake_evt_o
);
  logic [1:0] in_now;
  logic [1:0] prev_reg;
  logic [1:0] edge_hit;

  assign in_now = {shared_in_i, sense_in_i};
  assign edge_hit = (in_now ^ prev_reg) & {shared_wake_en_i, 1'b1} & {2{~meas_i}};
  assign wake_evt_o = |edge_hit;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prev_reg <= 2'h0;
      level_o <= 2'h0;
    end else if (!meas_i) begin
      prev_reg <= in_now;
      level_o <= in_now;
    end
  end

  // Set wins over a read clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) flags_o <= 2'h0;
    else flags_o <= (clr_flags_i ? 2'h0 : flags_o) | edge_hit;
  end
endmodule : hvmrc_wake_track

// [hvmrc_route_ctrl.sv]
// Our own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module hvmrc_route_ctrl
  import hvmrc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire hvmrc_pkg::hvmrc_av_req_t av_req_i,
  output hvmrc_pkg::hvmrc_av_rsp_t av_rsp_o,
  input wire hvmrc_pkg::hvmrc_mode_t mode_i,
  input wire logic hv_wake_sense_pin_i,
  input wire logic failout_shared_pin_i,
  input wire logic fail_output_req_i,
  output logic sense_route_switch_o,
  output hvmrc_pkg::hvmrc_pull_t pull_o,
  output logic fail_output_o,
  output logic shared_oe_n_o,
  output logic restart_req_o,
  output logic irq_o
);
  import hvmrc_pkg::*;

  logic hv_measure_enable_reg;
  logic [2:0] gpio_cfg_reg;
  logic [3:0] wake_pull_config_reg;
  logic [2:0] wake_source_ctrl_b_reg;
  logic fail_output_test_reg;
  logic [HVMRC_IRQ_W-1:0] irq_stat_reg;
  logic [HVMRC_IRQ_W-1:0] irq_mask_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  logic switch_reg;
  logic restart_reg;
  logic acc;
  logic wr;
  logic rd;
  logic [31:0] wd;
  logic meas_set_try;
  logic meas_refused;
  logic gpio_err;
  logic sleep_err;
  logic cmd_err;
  logic sense_in;
  logic shared_in;
  logic [1:0] wk_flags;
  logic [1:0] wk_level;
  logic wake_evt;
  logic shared_wake_en;
  logic [HVMRC_IRQ_W-1:0] irq_evt;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, answer in the next

  assign acc = (av_req_i.read | av_req_i.write) & ~ack_reg;
  assign wr = av_req_i.write & ~ack_reg;
  assign rd = av_req_i.read & ~ack_reg;
  assign wd = av_req_i.writedata;
  assign av_rsp_o.waitrequest = (av_req_i.read | av_req_i.write) & ~ack_reg;
  assign av_rsp_o.readdata = rdata_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) ack_reg <= 1'b0;
    else ack_reg <= acc;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0;
    end else if (rd) begin
      case (av_req_i.address)
        HVMRC_ADDR_CTRL: rdata_reg <= {31'h0, hv_measure_enable_reg};
        HVMRC_ADDR_GPIO: rdata_reg <= {29'h0, gpio_cfg_reg};
        HVMRC_ADDR_PULL: rdata_reg <= {28'h0, wake_pull_config_reg};
        HVMRC_ADDR_WKSRC: rdata_reg <= {29'h0, wake_source_ctrl_b_reg};
        HVMRC_ADDR_STAT: rdata_reg <= {29'h0, restart_reg, switch_reg, fail_output_test_reg};
        HVMRC_ADDR_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
        HVMRC_ADDR_IRQ_MASK: rdata_reg <= {29'h0, irq_mask_reg};
        HVMRC_ADDR_WKFLAG: rdata_reg <= {30'h0, wk_flags};
        HVMRC_ADDR_WKLVL: rdata_reg <= {30'h0, wk_level};
        default: rdata_reg <= 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration

  assign meas_set_try = wr && av_req_i.address == HVMRC_ADDR_CTRL && wd[HVMRC_CTRL_MEAS_BIT];
  assign meas_refused = meas_set_try && !hv_measure_enable_reg
                        && gpio_cfg_reg != HVMRC_GPIO_OFF;
  assign gpio_err = wr && av_req_i.address == HVMRC_ADDR_GPIO && hv_measure_enable_reg
                    && wd[3:0] != {fail_output_test_reg, gpio_cfg_reg};
  // Only gated pin sources armed: sleep cannot be woken
  assign sleep_err = wr && av_req_i.address == HVMRC_ADDR_CMD && wd[HVMRC_CMD_SLEEP_BIT]
                     && hv_measure_enable_reg
                     && !wake_source_ctrl_b_reg[HVMRC_WKSRC_OTHER_BIT];
  assign cmd_err = meas_refused | gpio_err | sleep_err;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) hv_measure_enable_reg <= 1'b0;
    else if (wr && av_req_i.address == HVMRC_ADDR_CTRL && !meas_refused)
      hv_measure_enable_reg <= wd[HVMRC_CTRL_MEAS_BIT];
  end

  // Writes still stored while measuring; pin gate ignores them
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      gpio_cfg_reg <= HVMRC_GPIO_OFF;
      wake_pull_config_reg <= HVMRC_PULL_RST;
      wake_source_ctrl_b_reg <= HVMRC_WKSRC_RST;
      fail_output_test_reg <= 1'b0;
    end else if (wr) begin
      case (av_req_i.address)
        HVMRC_ADDR_GPIO: begin
          gpio_cfg_reg <= wd[2:0];
          fail_output_test_reg <= wd[3];
        end
        HVMRC_ADDR_PULL: wake_pull_config_reg <= wd[3:0];
        HVMRC_ADDR_WKSRC: wake_source_ctrl_b_reg <= wd[2:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Switch and restart request

  always_ff @(posedge core_clk_i) begin
    if (rst_i) switch_reg <= 1'b0;
    else switch_reg <= hv_measure_enable_reg & (mode_i == HVMRC_MODE_NORMAL);
  end
  assign sense_route_switch_o = switch_reg;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) restart_reg <= 1'b0;
    else restart_reg <= sleep_err;
  end
  assign restart_req_o = restart_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Pins and wake tracking

  assign shared_wake_en = (gpio_cfg_reg == HVMRC_GPIO_WAKE)
                          & wake_source_ctrl_b_reg[HVMRC_WKSRC_GPIO_BIT];

  hvmrc_pin_gate u_gate (
    .meas_i(hv_measure_enable_reg),
    .pull_cfg_i(wake_pull_config_reg),
    .gpio_cfg_i(gpio_cfg_reg),
    .fail_output_req_i(fail_output_req_i),
    .fail_output_test_i(fail_output_test_reg),
    .hv_wake_sense_pin_i(hv_wake_sense_pin_i),
    .failout_shared_pin_i(failout_shared_pin_i),
    .pull_o(pull_o),
    .sense_in_o(sense_in),
    .shared_in_o(shared_in),
    .fail_output_o(fail_output_o),
    .shared_oe_n_o(shared_oe_n_o)
  );

  hvmrc_wake_track u_wake (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .sense_in_i(sense_in),
    .shared_in_i(shared_in),
    .meas_i(hv_measure_enable_reg),
    .shared_wake_en_i(shared_wake_en),
    .clr_flags_i(rd && av_req_i.address == HVMRC_ADDR_WKFLAG),
    .flags_o(wk_flags),
    .level_o(wk_level),
    .wake_evt_o(wake_evt)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupts: sticky, read clears, set wins

  assign irq_evt = {sleep_err, wake_evt, cmd_err};

  always_ff @(posedge core_clk_i) begin
    if (rst_i) irq_stat_reg <= '0;
    else if (rd && av_req_i.address == HVMRC_ADDR_IRQ_STAT) irq_stat_reg <= irq_evt;
    else irq_stat_reg <= irq_stat_reg | irq_evt;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) irq_mask_reg <= HVMRC_IRQ_MASK_RST;
    else if (wr && av_req_i.address == HVMRC_ADDR_IRQ_MASK) irq_mask_reg <= wd[2:0];
  end

  assign irq_o = |(irq_stat_reg & irq_mask_reg);
endmodule : hvmrc_route_ctrl

// [hvmrc_assertions.sv]
`timescale 1ns/1ps
module hvmrc_assertions
  import hvmrc_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire hvmrc_pkg::hvmrc_av_req_t av_req_i,
  input wire hvmrc_pkg::hvmrc_av_rsp_t av_rsp_o,
  input wire hvmrc_pkg::hvmrc_mode_t mode_i,
  input wire logic hv_wake_sense_pin_i,
  input wire logic failout_shared_pin_i,
  input wire logic fail_output_req_i,
  input wire logic sense_route_switch_o,
  input wire hvmrc_pkg::hvmrc_pull_t pull_o,
  input wire logic fail_output_o,
  input wire logic shared_oe_n_o,
  input wire logic restart_req_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  property p_rel;
    $fell(rst_i) |-> !sense_route_switch_o && pull_o == '0 && shared_oe_n_o && !irq_o;
  endproperty
  a_rel: assert property (p_rel) else $error("outputs not idle after reset");
  property p_sw_src;
    sense_route_switch_o |-> $past(mode_i) == HVMRC_MODE_NORMAL;
  endproperty
  a_sw_src: assert property (p_sw_src) else $error("switch closed outside normal");
  property p_sw_open;
    mode_i != HVMRC_MODE_NORMAL |=> !sense_route_switch_o;
  endproperty
  a_sw_open: assert property (p_sw_open) else $error("switch not opened");
  property p_sw_fs;
    $rose(mode_i == HVMRC_MODE_FAILSAFE) |=> !sense_route_switch_o [*2];
  endproperty
  a_sw_fs: assert property (p_sw_fs) else $error("switch closed in fail-safe");
  // Rising edge only: a clearing write may leave one cycle of overlap
  property p_pull;
    $rose(sense_route_switch_o) |-> pull_o == '0;
  endproperty
  a_pull: assert property (p_pull) else $error("pulls on while measuring");
  property p_fo;
    $rose(sense_route_switch_o) |-> shared_oe_n_o && !fail_output_o;
  endproperty
  a_fo: assert property (p_fo) else $error("shared pin driven while measuring");
  property p_pulse;
    restart_req_o |=> !restart_req_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("restart request too long");
  property p_cause;
    restart_req_o |-> $past(av_req_i.write && av_req_i.address == HVMRC_ADDR_CMD)
      || $past(av_req_i.write && av_req_i.address == HVMRC_ADDR_CMD, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("restart without sleep command");
  property p_wait;
    $rose(av_req_i.write) |-> av_rsp_o.waitrequest ##1 !av_rsp_o.waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("write not accepted");
  c_close: cover property ($rose(sense_route_switch_o));
  c_restart: cover property (restart_req_o);
  c_irq: cover property ($rose(irq_o));
endmodule : hvmrc_assertions
////////////////////////////////////////////////////////////////////////////////
bind hvmrc_route_ctrl hvmrc_assertions i_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .av_req_i(av_req_i), .av_rsp_o(av_rsp_o), .mode_i(mode_i),
  .hv_wake_sense_pin_i(hv_wake_sense_pin_i), .failout_shared_pin_i(failout_shared_pin_i),
  .fail_output_req_i(fail_output_req_i), .sense_route_switch_o(sense_route_switch_o),
  .pull_o(pull_o), .fail_output_o(fail_output_o), .shared_oe_n_o(shared_oe_n_o),
  .restart_req_o(restart_req_o), .irq_o(irq_o));

// [hvmrc_sw_model.sv]
`timescale 1ns/1ps
module hvmrc_sw_model
  import hvmrc_pkg::*;
(
  input wire logic core_clk_i,
  input wire hvmrc_pkg::hvmrc_av_rsp_t av_rsp_i,
  output hvmrc_pkg::hvmrc_av_req_t av_req_o
);
  initial av_req_o = '0;
  // Holds the request until waitrequest is seen low; no latency assumed
  task automatic xfer(input logic rd, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge core_clk_i);
    av_req_o <= '{address: a, read: rd, write: !rd, writedata: d};
    do @(posedge core_clk_i); while (av_rsp_i.waitrequest !== 1'b0);
    q = av_rsp_i.readdata;
    av_req_o <= '0;
  endtask : xfer
  task automatic measure_on();
    logic [31:0] d;
    xfer(1'b0, HVMRC_ADDR_GPIO, 32'(HVMRC_GPIO_OFF), d);
    xfer(1'b0, HVMRC_ADDR_CTRL, 32'h1, d);
  endtask : measure_on
endmodule : hvmrc_sw_model

// [tb_hvmrc_route_ctrl.sv]
`timescale 1ns/1ps
module tb_hvmrc_route_ctrl;
  import hvmrc_pkg::*;
  logic core_clk_i, rst_i, sense_pin, shared_pin, fo_req, sw, fo, oe_n, rst_req, irq;
  hvmrc_mode_t mode;
  hvmrc_av_req_t req;
  hvmrc_av_rsp_t rsp;
  hvmrc_pull_t pull;
  int mismatches, checks, cyc, pulses, pull_m;
  integer seed;
  logic [31:0] q;
  hvmrc_sw_model i_sw (.core_clk_i(core_clk_i), .av_rsp_i(rsp), .av_req_o(req));
  hvmrc_route_ctrl i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .av_req_i(req),
    .av_rsp_o(rsp), .mode_i(mode), .hv_wake_sense_pin_i(sense_pin),
    .failout_shared_pin_i(shared_pin), .fail_output_req_i(fo_req),
    .sense_route_switch_o(sw), .pull_o(pull), .fail_output_o(fo), .shared_oe_n_o(oe_n),
    .restart_req_o(rst_req), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc++;
    if (rst_req === 1'b1) pulses++;
    if (cyc == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
    i_sw.xfer(1'b1, a, 32'h0, q);
    chk(n, e, q);
  endtask : rd
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_sw.xfer(1'b0, a, d, q);
  endtask : wr
  // Samples at the falling edge so the launching edge has settled
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : settle
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_i = 1'b1; mode = HVMRC_MODE_NORMAL; sense_pin = 1'b0; shared_pin = 1'b0;
    fo_req = 1'b0; mismatches = 0; checks = 0; cyc = 0; pulses = 0; seed = 32'heaebd1c6;
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    settle(0);
    chk("switch", 0, 32'(sw));
    rd(HVMRC_ADDR_CTRL, 0, "ctrl");
    rd(HVMRC_ADDR_WKSRC, 32'(HVMRC_WKSRC_RST), "wksrc");
    wr(HVMRC_ADDR_GPIO, 32'(HVMRC_GPIO_FAILOUT) | 32'h8);
    settle(0);
    chk("fail test drive", 2, 32'({fo, oe_n}));
    wr(HVMRC_ADDR_CTRL, 1);
    rd(HVMRC_ADDR_CTRL, 0, "refused enable");
    rd(HVMRC_ADDR_IRQ_STAT, 1, "cmd error");
    $display("test reset and refusal done");
    pull_m = $random(seed) & 15;
    wr(HVMRC_ADDR_PULL, pull_m);
    i_sw.measure_on();
    fo_req <= 1'b1;
    settle(1);
    chk("switch", 1, 32'(sw));
    chk("pulls", 0, 32'(pull));
    chk("fail drive", 1, 32'({fo, oe_n}));
    rd(HVMRC_ADDR_PULL, pull_m, "pull kept");
    for (int m = 0; m < 6; m++) begin
      @(posedge core_clk_i);
      mode <= hvmrc_mode_t'(m);
      settle(1);
      chk("switch mode", 32'(m == 1), 32'(sw));
    end
    @(posedge core_clk_i);
    mode <= HVMRC_MODE_NORMAL;
    settle(1);
    chk("switch back", 1, 32'(sw));
    rd(HVMRC_ADDR_CTRL, 1, "enable kept");
    $display("test mode routing done");
    @(posedge core_clk_i);
    sense_pin <= 1'b1;
    shared_pin <= 1'b1;
    settle(4);
    rd(HVMRC_ADDR_WKFLAG, 0, "gated flags");
    rd(HVMRC_ADDR_WKLVL, 0, "frozen levels");
    wr(HVMRC_ADDR_GPIO, 32'(HVMRC_GPIO_FAILOUT));
    settle(0);
    chk("fail gated", 1, 32'({fo, oe_n}));
    rd(HVMRC_ADDR_IRQ_STAT, 1, "gpio change");
    wr(HVMRC_ADDR_GPIO, 32'(HVMRC_GPIO_FAILOUT) | 32'h8);
    rd(HVMRC_ADDR_IRQ_STAT, 1, "test bit change");
    wr(HVMRC_ADDR_IRQ_MASK, 7);
    wr(HVMRC_ADDR_CMD, 1);
    settle(1);
    chk("irq", 1, 32'(irq));
    rd(HVMRC_ADDR_IRQ_STAT, 5, "sleep error");
    wr(HVMRC_ADDR_WKSRC, 6);
    wr(HVMRC_ADDR_CMD, 1);
    settle(2);
    chk("irq cleared", 0, 32'(irq));
    chk("restart pulses", 1, pulses);
    $display("test measuring errors done");
    wr(HVMRC_ADDR_CTRL, 0);
    settle(1);
    chk("pulls back", pull_m, 32'(pull));
    chk("fail drive back", 2, 32'({fo, oe_n}));
    rd(HVMRC_ADDR_WKLVL, 3, "levels follow");
    wr(HVMRC_ADDR_GPIO, 32'(HVMRC_GPIO_WAKE));
    i_sw.xfer(1'b1, HVMRC_ADDR_WKFLAG, 32'h0, q);
    @(posedge core_clk_i);
    sense_pin <= 1'b0;
    shared_pin <= 1'b0;
    settle(4);
    rd(HVMRC_ADDR_WKFLAG, 3, "both wakes");
    rd(HVMRC_ADDR_WKLVL, 0, "levels");
    $display("test normal wake done");
    report_and_stop();
  end
endmodule : tb_hvmrc_route_ctrl
